//--- hw/cnidl_core.sv
// Startup computation of node identifier and bit-rate code.
// Assumes pins and switch are stable during the first cycle after reset release.
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
module cnidl_core
  import cnidl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] pins_i,
  input  wire logic [3:0]  switch_i,
  input  wire logic        has_switch_i,
  input  wire logic        alt_mode_i,
  input  wire logic        net_enable_i,
  cnidl_cfg_if.core        cfg
);
  cnidl_state_t state;
  logic [15:0]  pin_snap;
  logic [3:0]   sw_snap;
  logic [15:0]  cfg_snap;
  logic [31:0]  map_snap;
  logic [6:0]   pin_val;

  // Pin contribution: default uses top N pins, mapped uses nibbles
  function automatic logic [6:0] cnidl_pin_value(input logic [15:0] p, input logic [31:0] m,
                                                 input logic [2:0] n);
    logic [6:0] v;
    logic [4:0] base;
    v    = 7'h00;
    base = 5'(CNIDL_NUM_PINS) - {2'b00, n};
    for (int b = 0; b < CNIDL_ID_W; b++) begin
      if (b < int'(n)) begin // R15
        if (m[CNIDL_MAP_EN_BIT]) begin // R11
          v[b] = p[m[b*CNIDL_MAP_NIB_W +: CNIDL_MAP_NIB_W]]; // R10 R13
        end else begin
          v[b] = p[4'(base + 5'(b))]; // R12
        end
      end
    end
    return v;
  endfunction

  assign pin_val = cnidl_pin_value(pin_snap, map_snap, cfg_snap[CNIDL_PCNT_LSB +: CNIDL_PCNT_W]); // R7

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= CNIDL_ST_SAMPLE;
    end else begin
      case (state)
        CNIDL_ST_SAMPLE: state <= CNIDL_ST_CALC;
        CNIDL_ST_CALC:   state <= CNIDL_ST_DONE;
        CNIDL_ST_DONE:   state <= CNIDL_ST_DONE;
        default:         state <= CNIDL_ST_SAMPLE;
      endcase
    end
  end

  // One sample after reset; pins are free afterwards
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_snap <= 16'h0000;
      sw_snap  <= 4'h0;
      cfg_snap <= 16'h0000;
      map_snap <= 32'h00000000;
    end else if (state == CNIDL_ST_SAMPLE) begin
      pin_snap <= pins_i; // R14
      sw_snap  <= switch_i;
      cfg_snap <= cfg.net_cfg;
      map_snap <= cfg.pin_map;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg.active_id    <= 7'h00;
      cfg.active_rate  <= 4'h0;
      cfg.active_valid <= 1'b0;
    end else if (state == CNIDL_ST_CALC) begin // R2
      cfg.active_rate  <= cfg_snap[CNIDL_RATE_LSB +: CNIDL_RATE_W]; // R1 R9
      cfg.active_valid <= 1'b1;
      if (has_switch_i && cfg_snap[CNIDL_SW_EN_BIT]) begin // R8
        cfg.active_id <= 7'({pin_val, 4'h0} + {3'b000, sw_snap} +
                            {4'h0, cfg_snap[CNIDL_OFS_LSB +: CNIDL_OFS_W]}); // R3
      end else begin
        cfg.active_id <= 7'(pin_val + cfg_snap[CNIDL_OFS_LSB +: CNIDL_OFS_W]); // R3 R5
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg.sw_disabled <= 1'b0;
    end else if (state == CNIDL_ST_CALC) begin
      cfg.sw_disabled <= alt_mode_i && cfg_snap[CNIDL_ALT_DIS_BIT]; // R6
    end else if (net_enable_i) begin
      cfg.sw_disabled <= 1'b0; // R6
    end
  end
endmodule

//--- hw/cnidl_pkg.sv
// Package for the node identifier and bit-rate loader.
// Assumes a single 200 MHz clock and a plain register port on the top module.
package cnidl_pkg;
  // ---------------------------------------------------------------
  // Register map (printed offsets kept as indices)
  // ---------------------------------------------------------------
  localparam logic [15:0] CNIDL_IDX_FW_UPDATE = 16'h2001;
  localparam logic [15:0] CNIDL_IDX_NET_CFG   = 16'h21B0;
  localparam logic [15:0] CNIDL_IDX_PIN_MAP   = 16'h21B1;
  localparam logic [15:0] CNIDL_IDX_STATUS    = 16'h21B2;

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  localparam int CNIDL_OFS_LSB      = 0;
  localparam int CNIDL_OFS_W        = 7;
  localparam int CNIDL_ALT_DIS_BIT  = 7;
  localparam int CNIDL_PCNT_LSB     = 8;
  localparam int CNIDL_PCNT_W       = 3;
  localparam int CNIDL_SW_EN_BIT    = 11;
  localparam int CNIDL_RATE_LSB     = 12;
  localparam int CNIDL_RATE_W       = 4;
  localparam int CNIDL_MAP_NIB_W    = 4;
  localparam int CNIDL_MAP_EN_BIT   = 31;
  localparam int CNIDL_SW_SHIFT     = 4;
  localparam int CNIDL_ID_W         = 7;
  localparam int CNIDL_NUM_PINS     = 16;
  localparam logic [3:0] CNIDL_RATE_MAX_VALID = 4'h6;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [15:0] CNIDL_NET_CFG_RST = 16'h0000;
  localparam logic [31:0] CNIDL_PIN_MAP_RST = 32'h00000000;
  localparam logic [31:0] CNIDL_FW_RST      = 32'h00000000;

  // ---------------------------------------------------------------
  // Startup sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CNIDL_ST_SAMPLE = 3'b001,
    CNIDL_ST_CALC   = 3'b010,
    CNIDL_ST_DONE   = 3'b100
  } cnidl_state_t;
endpackage

//--- hw/cnidl_cfg_if.sv
// Interface carrying stored configuration from the register file to the core.
// Assumes both ends share CLK_I.
`timescale 1ns/1ps
interface cnidl_cfg_if;
  logic [15:0] net_cfg;
  logic [31:0] pin_map;
  logic        active_valid;
  logic [6:0]  active_id;
  logic [3:0]  active_rate;
  logic        sw_disabled;
  modport regs (output net_cfg, output pin_map, input active_valid, input active_id,
                input active_rate, input sw_disabled);
  modport core (input net_cfg, input pin_map, output active_valid, output active_id,
                output active_rate, output sw_disabled);
endinterface

//--- hw/cnidl_regs.sv
// Register file for the loader: stored configuration and status readback.
// Assumes a single-cycle strobe master; reads answer one cycle later.
`timescale 1ns/1ps
module cnidl_regs
  import cnidl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [15:0] addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             nv_commit_o,
  cnidl_cfg_if.regs        cfg
);
  logic [31:0] fw_port;

  // The two config words stand for the nonvolatile store, so reset leaves them alone
  // Limitation: their power-up contents must be loaded by writes, or startup sees unknowns
  always_ff @(posedge clk_i) begin
    if (wr_i) begin
      case (addr_i)
        CNIDL_IDX_NET_CFG: cfg.net_cfg <= wdata_i[15:0]; // R4
        CNIDL_IDX_PIN_MAP: cfg.pin_map <= wdata_i; // R4
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fw_port <= CNIDL_FW_RST;
    end else if (wr_i && addr_i == CNIDL_IDX_FW_UPDATE) begin
      fw_port <= wdata_i;
    end
  end

  // Commit pulse to nonvolatile storage on config writes
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      nv_commit_o <= 1'b0;
    end else begin
      nv_commit_o <= wr_i && (addr_i == CNIDL_IDX_NET_CFG || addr_i == CNIDL_IDX_PIN_MAP); // R4
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (rd_i) begin
      case (addr_i)
        CNIDL_IDX_NET_CFG:   rdata_o <= {16'h0000, cfg.net_cfg};
        CNIDL_IDX_PIN_MAP:   rdata_o <= cfg.pin_map;
        CNIDL_IDX_FW_UPDATE: rdata_o <= fw_port;
        CNIDL_IDX_STATUS:    rdata_o <= {18'h00000, cfg.sw_disabled, cfg.active_valid,
                                         cfg.active_rate, 1'b0, cfg.active_id};
        default:             rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end
endmodule

//--- hw/cnidl_top.sv
// Top of the node identifier and bit-rate loader.
// Assumes synchronous inputs on CLK_I and an external nonvolatile store fed by NV_COMMIT_O.
//
// Notes on behaviour
// R1: Bit-rate code is latched only at reset.
// R2: Node identifier is computed once after each reset.
// R3: Identifier keeps only its low seven bits.
// R4: Config writes are committed to storage and act after next reset.
// R5: Config bits 0-6 are the identifier offset.
// R6: Alternate mode with bit 7 starts disabled until network enable arrives.
// R7: Config bits 8-10 give number of pins sampled.
// R8: With switch and bit 11, id is pins shifted four plus switch plus offset.
// R9: Config bits 12-15 are the bit-rate code; 7-15 reserved.
// R10: Mapping nibbles name the pin for identifier bits 0-6.
// R11: Mapping bit 31 enables nibbles, otherwise default mapping.
// R12: Default mapping uses the N highest pins, lowest to bit 0.
// R13: Mapped pin numbers range 0 to 15.
// R14: Pins are sampled once at startup only.
// R15: Zero pin count gives zero pin contribution.
`timescale 1ns/1ps
module cnidl_top
  import cnidl_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [15:0] ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O,
  input  wire logic [15:0] GP_PINS_I,
  input  wire logic [3:0]  ADDR_SWITCH_I,
  input  wire logic        HAS_SWITCH_I,
  input  wire logic        ALT_FIELDBUS_I,
  input  wire logic        NET_ENABLE_I,
  output logic [6:0]       NODE_ID_O,
  output logic [3:0]       BIT_RATE_O,
  output logic             RATE_RESERVED_O,
  output logic             CONFIG_VALID_O,
  output logic             SW_DISABLED_O,
  output logic             NV_COMMIT_O
);
  cnidl_cfg_if cfg ();

  cnidl_regs u_regs (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .addr_i      (ADDR_I),
    .wdata_i     (WDATA_I),
    .wr_i        (WR_I),
    .rd_i        (RD_I),
    .rdata_o     (RDATA_O),
    .nv_commit_o (NV_COMMIT_O),
    .cfg         (cfg)
  );

  cnidl_core u_core (
    .clk_i        (CLK_I),
    .rst_n_i      (RST_N_I),
    .pins_i       (GP_PINS_I),
    .switch_i     (ADDR_SWITCH_I),
    .has_switch_i (HAS_SWITCH_I),
    .alt_mode_i   (ALT_FIELDBUS_I),
    .net_enable_i (NET_ENABLE_I),
    .cfg          (cfg)
  );

  assign NODE_ID_O       = cfg.active_id;
  assign BIT_RATE_O      = cfg.active_rate;
  assign RATE_RESERVED_O = cfg.active_valid && (cfg.active_rate > CNIDL_RATE_MAX_VALID); // R9
  assign CONFIG_VALID_O  = cfg.active_valid;
  assign SW_DISABLED_O   = cfg.sw_disabled;
endmodule

//--- verification/cnidl_pin_model.sv
// Model of the input pins and the address selector switch.
// Assumes the loader samples them in the first cycles after reset release.
`timescale 1ns/1ps
module cnidl_pin_model (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  output logic [15:0]      pins_o,
  output logic [3:0]       switch_o
);
  logic [2:0] age;
  assign switch_o = 4'h5;
  // Pins hold a startup pattern, then are reused and toggle every cycle
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      age    <= 3'h0;
      pins_o <= 16'hE000;
    end else if (age != 3'h4) begin
      age <= age + 3'h1;
    end else begin
      pins_o <= ~pins_o;
    end
  end
endmodule

//--- verification/cnidl_monitor.sv
// Port checker for the loader top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module cnidl_monitor (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic [15:0] ADDR_I,
  input wire logic        WR_I,
  input wire logic        RD_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        NET_ENABLE_I,
  input wire logic [6:0]  NODE_ID_O,
  input wire logic [3:0]  BIT_RATE_O,
  input wire logic        RATE_RESERVED_O,
  input wire logic        CONFIG_VALID_O,
  input wire logic        SW_DISABLED_O,
  input wire logic        NV_COMMIT_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence s_release;
    !RST_N_I ##1 RST_N_I;
  endsequence
  sequence s_cfg_write;
    WR_I && (ADDR_I == 16'h21B0 || ADDR_I == 16'h21B1);
  endsequence
  a_valid_after_release: assert property (disable iff (1'b0) s_release |-> ##[1:2] CONFIG_VALID_O)
    else $error("config valid late after reset");
  a_valid_holds: assert property (CONFIG_VALID_O |=> CONFIG_VALID_O)
    else $error("config valid dropped");
  a_active_stable: assert property (CONFIG_VALID_O |=> $stable(NODE_ID_O) && $stable(BIT_RATE_O))
    else $error("active id or rate changed");
  a_idle_before_valid: assert property (!CONFIG_VALID_O |-> NODE_ID_O == 7'h00 && BIT_RATE_O == 4'h0)
    else $error("outputs set before valid");
  a_rate_reserved: assert property (RATE_RESERVED_O == (BIT_RATE_O > 4'h6))
    else $error("reserved rate flag wrong");
  a_commit_follows: assert property (s_cfg_write |=> NV_COMMIT_O)
    else $error("no commit after config write");
  a_commit_cause: assert property (NV_COMMIT_O |-> $past(WR_I) && $past(ADDR_I[15:1]) == 15'h10D8)
    else $error("commit without config write");
  a_rdata_quiet: assert property (!$past(RD_I) |-> RDATA_O == 32'h00000000)
    else $error("read data outside read slot");
  a_enable_clears: assert property (SW_DISABLED_O && NET_ENABLE_I |=> !SW_DISABLED_O)
    else $error("network enable ignored");
endmodule
bind cnidl_top cnidl_monitor mon (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .ADDR_I(ADDR_I), .WR_I(WR_I),
  .RD_I(RD_I), .RDATA_O(RDATA_O), .NET_ENABLE_I(NET_ENABLE_I), .NODE_ID_O(NODE_ID_O),
  .BIT_RATE_O(BIT_RATE_O), .RATE_RESERVED_O(RATE_RESERVED_O), .CONFIG_VALID_O(CONFIG_VALID_O),
  .SW_DISABLED_O(SW_DISABLED_O), .NV_COMMIT_O(NV_COMMIT_O));

//--- verification/cnidl_bench.sv
// Self-checking bench for the loader top.
// Assumes the config words survive reset; their power-up contents are written while reset is held.
`timescale 1ns/1ps
module cnidl_bench;
  logic        clk = 1'b0, rst_n = 1'b0, wr_s = 1'b0, rd_s = 1'b0, net_en = 1'b0;
  logic        has_sw = 1'b1, alt = 1'b1;
  logic [15:0] addr = 16'h0000, pins;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0]  sw, rate;
  logic [6:0]  id;
  logic        rsv, valid, dis, commit;
  int          error_cnt = 0, tests_run = 0;
  logic [15:0] r_addr [4] = '{16'h21B0, 16'h21B1, 16'h2001, 16'h1234};
  logic [31:0] r_wr   [4] = '{32'hFFFF3B85, 32'h70000000, 32'hA5A55A5A, 32'hFFFFFFFF};
  logic [31:0] r_exp  [4] = '{32'h00003B85, 32'h70000000, 32'hA5A55A5A, 32'h00000000};
  logic        r_cmt  [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
  always #2.5 clk = ~clk;
  cnidl_pin_model pm (.clk_i(clk), .rst_n_i(rst_n), .pins_o(pins), .switch_o(sw));
  cnidl_top uut (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr_s),
    .RD_I(rd_s), .RDATA_O(rdata), .GP_PINS_I(pins), .ADDR_SWITCH_I(sw), .HAS_SWITCH_I(has_sw),
    .ALT_FIELDBUS_I(alt), .NET_ENABLE_I(net_en), .NODE_ID_O(id), .BIT_RATE_O(rate),
    .RATE_RESERVED_O(rsv), .CONFIG_VALID_O(valid), .SW_DISABLED_O(dis), .NV_COMMIT_O(commit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clk);
    wr_s <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [31:0] v);
    @(posedge clk);
    rd_s <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask
  // Bounded wait for startup; a hang is counted and ends the run
  task automatic do_reset;
    int n;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    n = 0;
    #1;
    while (valid !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 8) begin
      error_cnt++;
      conclude();
    end
  endtask
  // Active outputs after startup; valid must always be up by then
  task automatic chk_active(input logic [6:0] e_id, input logic [3:0] e_rate, input logic e_rsv,
                            input logic e_dis);
    chk({20'h0, rsv, rate, id}, {20'h0, e_rsv, e_rate, e_id});
    chk({30'h0, dis, valid}, {30'h0, e_dis, 1'b1});
  endtask
  initial begin
    // Power-up contents of the store, written while reset is still held
    wr(16'h21B0, 32'h00000000);
    wr(16'h21B1, 32'h00000000);
    do_reset();
    chk_active(7'h00, 4'h0, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(r_addr[i], r_wr[i]);
      #1 chk({31'h0, commit}, {31'h0, r_cmt[i]});
      rd(r_addr[i], d);
      chk(d, r_exp[i]);
      chk_active(7'h00, 4'h0, 1'b0, 1'b0);
    end
    rd(16'h21B2, d);
    chk(d, 32'h00001000);
    @(posedge clk);
    net_en <= 1'b1;
    repeat (6) @(posedge clk);
    net_en <= 1'b0;
    chk_active(7'h00, 4'h0, 1'b0, 1'b0);
    // Offset 5, three top pins by default, switch 5 on, rate 3, alternate mode disable set
    do_reset();
    chk_active(7'h7A, 4'h3, 1'b0, 1'b1);
    rd(16'h21B2, d);
    chk(d, 32'h0000337A);
    @(posedge clk);
    net_en <= 1'b1;
    @(posedge clk);
    net_en <= 1'b0;
    #1 chk({31'h0, dis}, 32'h00000000);
    // No switch, normal mode: mapped pins 14, 13, 0 plus offset 0x7E wraps to 1
    @(posedge clk);
    has_sw <= 1'b0;
    alt <= 1'b0;
    wr(16'h21B0, 32'h00007BFE);
    wr(16'h21B1, 32'h800000DE);
    #1 chk_active(7'h7A, 4'h3, 1'b0, 1'b0);
    do_reset();
    chk_active(7'h01, 4'h7, 1'b1, 1'b0);
    rd(16'h21B0, d);
    chk(d, 32'h00007BFE);
    conclude();
  end
endmodule
